// ---- hw/scp_pkg.sv ----
// Package for the system clock prescaler: register map, field layout, reset values
// Assumes a 32-bit APB slave port clocked by the undivided master clock
package scp_pkg;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] SCP_OFF_DIVIDE_CONTROL = 8'h00;
   localparam logic [7:0] SCP_OFF_OSCILLATOR_TRIM = 8'h04;
   localparam logic [7:0] SCP_OFF_TIMER_OSC_CTRL = 8'h08;
   localparam logic [7:0] SCP_OFF_STATUS = 8'h0C;

   // ----------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------
   localparam int SCP_CHANGE_ENABLE_BIT = 7;
   localparam int SCP_TRIM_RANGE_BIT = 7;
   localparam logic [3:0] SCP_DIV_RESET_PLAIN = 4'h0;
   localparam logic [3:0] SCP_DIV_RESET_DIV8 = 4'h3;
   localparam logic [3:0] SCP_DIV_MAX_CODE = 4'h8;
   localparam logic [2:0] SCP_CHANGE_WINDOW_CYCLES = 3'h4;
   localparam int SCP_DIV_COUNT_W = 8;

   typedef enum logic [1:0]
   {
      SCP_RUN = 2'b00,
      SCP_WAIT_OLD = 2'b01,
      SCP_WAIT_NEW = 2'b10
   } scp_phase_t;

   typedef struct packed
   {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } scp_apb_req_t;

   typedef struct packed
   {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } scp_apb_rsp_t;

   typedef struct packed
   {
      logic io_domain_clock;
      logic converter_domain_clock;
      logic core_domain_clock;
      logic program_memory_clock;
   } scp_domain_en_t;

endpackage

// ---- hw/scp_prescaler.sv ----
// System clock prescaler with timed change sequence, clock output and trim register
// Assumes clk_sys is the undivided master clock; divided clocks leave as one-cycle enables
module scp_prescaler
   import scp_pkg::*;
(
   input wire logic clk_sys, // Undivided master clock
   input wire logic rst, // Synchronous chip reset, active high
   input wire scp_apb_req_t apb_req, // APB request
   output scp_apb_rsp_t apb_rsp, // APB response
   input wire logic clock_out_fuse, // Clock output fuse programmed
   input wire logic start_div8_fuse, // Divide-by-eight fuse programmed
   input wire logic [7:0] factory_trim, // Factory calibration byte
   input wire logic rc_source_selected, // Internal RC oscillator is system source
   input wire logic port_pin_out, // Normal port value for the clock pin
   input wire logic port_pin_oe, // Normal port enable for the clock pin
   output scp_domain_en_t domain_en, // Divided clock enables per domain
   output logic clock_out_pin, // Clock output pin level
   output logic clock_out_pin_oe, // Clock output pin drive enable
   output logic [7:0] oscillator_trim, // Trim value to the RC oscillator
   output logic timer_osc_enable, // Timer oscillator running on crystal pins
   output logic ext_timer_clock_select // External clock on timer_osc_pin_a
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   // All state of the block; cleared or loaded while rst is high, except the divider count, clock level and, with the fuse set, the pin
   typedef struct packed
   {
      scp_apb_rsp_t rsp;
      logic [3:0] divide_select;
      logic [3:0] active_select;
      logic divide_change_enable;
      logic [2:0] window_count;
      logic [SCP_DIV_COUNT_W-1:0] div_count;
      scp_phase_t phase;
      logic in_reset;
      logic clk_level;
      scp_domain_en_t dom;
      logic pin;
      logic pin_oe;
      logic [7:0] trim;
      logic trim_loaded;
      logic timer_osc_req;
      logic ext_clk_sel;
      logic tosc_on;
   } scp_state_t;

   scp_state_t st;
   scp_state_t next_st;

   // Period in master cycles minus one for a select code
   function automatic logic [SCP_DIV_COUNT_W-1:0] scp_period_m1(input logic [3:0] code);
      logic [8:0] full;
      full = 9'h001 << code;
      scp_period_m1 = SCP_DIV_COUNT_W'(full - 9'h001);
   endfunction

   // Divider wraps at the end of the period of the code it is running
   function automatic logic scp_tick(input scp_state_t s);
      scp_tick = (s.div_count == scp_period_m1(s.active_select));
   endfunction

   // Codes above the largest factor are reserved: stored, applied only if written while a switch waits in SCP_WAIT_OLD
   function automatic logic scp_code_ok(input logic [3:0] code);
      scp_code_ok = (code <= SCP_DIV_MAX_CODE);
   endfunction

   // One aligned word per register
   function automatic logic scp_hit(input logic [7:0] addr, input logic [7:0] offset);
      scp_hit = (addr == offset);
   endfunction

   // Status byte: active code, timer oscillator on, switch pending, reserved select
   function automatic logic [7:0] scp_status(input scp_state_t s);
      scp_status = {s.active_select, 1'b0, s.tosc_on, s.phase != SCP_RUN, !scp_code_ok(s.divide_select)};
   endfunction

   logic apb_access;
   logic apb_wr;
   logic [7:0] wbyte;
   logic tick_now;
   logic half_now;
   logic apb_done;
   logic wr_divide;
   logic wr_trim;
   logic wr_timer;
   logic wr_bad;
   logic window_done;
   wire logic [3:0] dom_next;

   // ----------------------------------------------------------------
   // Register map (one aligned 32-bit word each, byte 0 used)
   // ----------------------------------------------------------------
   // 0x00 divide control: bit 7 change enable, bits 3:0 select code
   // 0x04 oscillator trim: bit 7 range, bits 6:0 fine tuning
   // 0x08 timer oscillator: bit 1 external clock, bit 0 oscillator request
   // 0x0C status, read only: bits 7:4 active code, bit 2 timer oscillator on,
   //      bit 1 switch pending, bit 0 reserved select code held
   // Reads of other addresses, and writes above 0x0C, answer with a slave error
   // Transfers: setup, then access; pready follows one cycle later and stands one cycle
   // Read data is registered with pready; writes land at the edge that completes the transfer
   // A divide change is 0x80, then the code in a back-to-back transfer, inside four cycles

   // ----------------------------------------------------------------
   // Domain enables: every domain takes the same divided tick
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin
         assign dom_next[gi] = scp_tick(st);
      end
   endgenerate

   always_comb
   begin
      next_st = st;
      apb_access = apb_req.psel && apb_req.penable && !st.rsp.pready;
      // A write lands at the edge that completes the transfer, when pready is seen high
      apb_done = apb_req.psel && apb_req.penable && st.rsp.pready;
      apb_wr = apb_done && apb_req.pwrite;
      wbyte = apb_req.pwdata[7:0];

      // ----------------------------------------------------------------
      // Request decode
      // ----------------------------------------------------------------
      wr_divide = apb_wr && scp_hit(apb_req.paddr, SCP_OFF_DIVIDE_CONTROL);
      wr_trim = apb_wr && scp_hit(apb_req.paddr, SCP_OFF_OSCILLATOR_TRIM);
      wr_timer = apb_wr && scp_hit(apb_req.paddr, SCP_OFF_TIMER_OSC_CTRL);
      wr_bad = apb_access && apb_req.pwrite && apb_req.paddr > SCP_OFF_STATUS;
      window_done = (st.window_count == SCP_CHANGE_WINDOW_CYCLES - 3'h1);
      next_st.rsp.pready = apb_access;
      next_st.rsp.pslverr = 1'b0;
      next_st.rsp.prdata = 32'h0000_0000;

      // ----------------------------------------------------------------
      // Change-enable window
      // ----------------------------------------------------------------
      // The window counts master cycles; it closes on the fourth edge after opening
      if (st.divide_change_enable)
      begin
         if (window_done)
         begin
            next_st.divide_change_enable = 1'b0;
         end
         next_st.window_count = st.window_count + 3'h1;
      end

      if (wr_divide)
      begin
         if (wbyte == 8'h80)
         begin
            if (!st.divide_change_enable)
            begin
               next_st.divide_change_enable = 1'b1;
               next_st.window_count = 3'h0;
            end
            // An open window is left alone by a repeated enable write
         end
         else if (!wbyte[SCP_CHANGE_ENABLE_BIT] && st.divide_change_enable)
         begin
            next_st.divide_select = wbyte[3:0];
            next_st.divide_change_enable = 1'b0;
         end
         // Select writes without an open window are dropped
      end

      // ----------------------------------------------------------------
      // Oscillator trim and timer oscillator control
      // ----------------------------------------------------------------
      // The factory byte is reloaded under reset; software may overwrite it later
      if (!st.trim_loaded)
      begin
         next_st.trim = factory_trim;
         next_st.trim_loaded = 1'b1;
      end
      if (wr_trim)
      begin
         next_st.trim = wbyte;
      end
      if (wr_timer)
      begin
         next_st.timer_osc_req = wbyte[0];
         next_st.ext_clk_sel = wbyte[1];
      end
      // The timer oscillator shares the crystal pins, so it runs only on the RC source
      next_st.tosc_on = st.timer_osc_req && rc_source_selected;

      // ----------------------------------------------------------------
      // Register read
      // ----------------------------------------------------------------
      // Read data is taken at the first access edge and stands beside pready
      if (apb_access && !apb_req.pwrite)
      begin
         unique case (apb_req.paddr)
            SCP_OFF_DIVIDE_CONTROL:
            begin
               next_st.rsp.prdata = {24'h00_0000, st.divide_change_enable, 3'h0, st.divide_select};
            end
            SCP_OFF_OSCILLATOR_TRIM:
            begin
               next_st.rsp.prdata = {24'h00_0000, st.trim};
            end
            SCP_OFF_TIMER_OSC_CTRL:
            begin
               next_st.rsp.prdata = {30'h0000_0000, st.ext_clk_sel, st.timer_osc_req};
            end
            SCP_OFF_STATUS:
            begin
               next_st.rsp.prdata = {24'h00_0000, scp_status(st)};
            end
            default:
            begin
               next_st.rsp.pslverr = 1'b1;
            end
         endcase
      end
      else if (wr_bad)
      begin
         next_st.rsp.pslverr = 1'b1;
      end

      // ----------------------------------------------------------------
      // Divider
      // ----------------------------------------------------------------
      // Rise on the wrap, fall at mid-period: about half duty for every even factor
      tick_now = scp_tick(st);
      half_now = (st.div_count == (scp_period_m1(st.active_select) >> 1));
      next_st.div_count = tick_now ? '0 : st.div_count + SCP_DIV_COUNT_W'(1);
      next_st.in_reset = rst;
      if (st.active_select == 4'h0)
      begin
         next_st.clk_level = ~st.clk_level;
      end
      else if (tick_now)
      begin
         next_st.clk_level = 1'b1;
      end
      else if (half_now)
      begin
         next_st.clk_level = 1'b0;
      end

      // ----------------------------------------------------------------
      // Rate switch
      // ----------------------------------------------------------------
      // A pending code waits for the old period to end, so no pulse is shorter than either rate
      // Switch only at an old-period boundary, then run one new period
      unique case (st.phase)
         SCP_RUN:
         begin
            if (st.divide_select != st.active_select && scp_code_ok(st.divide_select))
            begin
               next_st.phase = SCP_WAIT_OLD;
            end
         end
         SCP_WAIT_OLD:
         begin
            if (tick_now)
            begin
               next_st.active_select = st.divide_select;
               next_st.phase = SCP_WAIT_NEW;
            end
         end
         SCP_WAIT_NEW:
         begin
            if (tick_now)
            begin
               next_st.phase = SCP_RUN;
            end
         end
         default:
         begin
            next_st.phase = SCP_RUN;
         end
      endcase

      next_st.dom = dom_next;

      // ----------------------------------------------------------------
      // Clock output pin
      // ----------------------------------------------------------------
      // With the fuse set the pin carries the clock in every state, reset included;
      // otherwise the port's own value passes through one register, and reset holds pin and enable low
      if (clock_out_fuse)
      begin
         next_st.pin = st.clk_level;
         next_st.pin_oe = 1'b1;
      end
      else
      begin
         next_st.pin = port_pin_out;
         next_st.pin_oe = port_pin_oe;
      end

      if (rst)
      begin
         next_st.rsp = '0;
         next_st.divide_select = start_div8_fuse ? SCP_DIV_RESET_DIV8 : SCP_DIV_RESET_PLAIN;
         next_st.active_select = next_st.divide_select;
         next_st.divide_change_enable = 1'b0;
         next_st.window_count = 3'h0;
         next_st.phase = SCP_RUN;
         next_st.trim = factory_trim;
         next_st.trim_loaded = 1'b1;
         next_st.timer_osc_req = 1'b0;
         next_st.ext_clk_sel = 1'b0;
         next_st.tosc_on = 1'b0;
         next_st.dom = '0;
         if (!clock_out_fuse)
         begin
            next_st.pin = 1'b0;
            next_st.pin_oe = 1'b0;
         end
         // Divider and, with the fuse set, the pin keep toggling through reset
         // The counter restarts once, on entry, so it never runs on from an unknown count;
         // a reset in mid-run may therefore shorten one output period
         if (st.in_reset)
         begin
            next_st.in_reset = 1'b1;
         end
         else
         begin
            next_st.div_count = '0;
            next_st.clk_level = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      st <= next_st;
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from the state register
   // ----------------------------------------------------------------
   assign apb_rsp = st.rsp;
   assign domain_en = st.dom;
   assign clock_out_pin = st.pin;
   assign clock_out_pin_oe = st.pin_oe;
   assign oscillator_trim = st.trim;
   assign timer_osc_enable = st.tosc_on;
   assign ext_timer_clock_select = st.ext_clk_sel;

endmodule

// ---- tb/scp_monitor.sv ----
// Port checker for the clock prescaler
// Bound to scp_prescaler; sees only its ports
module scp_monitor
   import scp_pkg::*;
(
   input wire logic clk_sys, // Clock
   input wire logic rst, // Reset
   input wire scp_apb_req_t apb_req, // Request
   input wire scp_apb_rsp_t apb_rsp, // Response
   input wire logic clock_out_fuse, // Fuse
   input wire logic [7:0] factory_trim, // Trim at reset
   input wire logic rc_source_selected, // RC source
   input wire logic port_pin_oe, // Port enable
   input wire scp_domain_en_t domain_en, // Enables
   input wire logic clock_out_pin_oe, // Pin enable
   input wire logic [7:0] oscillator_trim, // Trim
   input wire logic timer_osc_enable // Timer osc
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Pulse spacing and port relations
   // ----------------------------------------
   logic [8:0] gap;
   logic armed;
   wire logic pulse = domain_en.core_domain_clock;
   always_ff @(posedge clk_sys)
   begin
      armed <= !rst && (armed || pulse);
      gap <= (rst || pulse) ? 9'h001 : gap + 9'h001;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_oe; disable iff (1'b0) clock_out_fuse |=> clock_out_pin_oe; endproperty
   a_oe: assert property (p_oe) else $error("pin not driven");
   property p_pass; !clock_out_fuse |=> clock_out_pin_oe == $past(port_pin_oe); endproperty
   a_pass: assert property (p_pass) else $error("port enable lost");
   property p_trim; disable iff (1'b0) rst |=> oscillator_trim == $past(factory_trim); endproperty
   a_trim: assert property (p_trim) else $error("trim not loaded");
   property p_quiet; disable iff (1'b0) rst |=> domain_en == 4'h0; endproperty
   a_quiet: assert property (p_quiet) else $error("enables in reset");
   property p_same; domain_en == {4{pulse}}; endproperty
   a_same: assert property (p_same) else $error("domains differ");
   property p_ready; apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready; endproperty
   a_ready: assert property (p_ready) else $error("no ready");
   property p_err; apb_rsp.pready |-> apb_rsp.pslverr == (apb_req.paddr > 8'h0C); endproperty
   a_err: assert property (p_err) else $error("wrong slave error");
   property p_timer; !$past(rc_source_selected) |-> !timer_osc_enable; endproperty
   a_timer: assert property (p_timer) else $error("timer osc without RC");
   property p_gap; pulse && armed |-> gap <= 9'h100 && (gap & (gap - 9'h001)) == 9'h000; endproperty
   a_gap: assert property (p_gap) else $error("odd pulse spacing");
   c_write: cover property (apb_rsp.pready && apb_req.pwrite);
   c_err: cover property (apb_rsp.pready && apb_rsp.pslverr);
   c_slow: cover property (pulse && armed && gap == 9'h100);
endmodule

bind scp_prescaler scp_monitor scp_monitor_inst (.clk_sys(clk_sys), .rst(rst), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .clock_out_fuse(clock_out_fuse), .factory_trim(factory_trim),
   .rc_source_selected(rc_source_selected), .port_pin_oe(port_pin_oe), .domain_en(domain_en),
   .clock_out_pin_oe(clock_out_pin_oe), .oscillator_trim(oscillator_trim), .timer_osc_enable(timer_osc_enable));

// ---- tb/scp_clock_sink.sv ----
// Far side: a circuit clocked from the output pin
// Samples on clk_sys; a released pin reads as the inverse of its last level
module scp_clock_sink
(
   input wire logic clk_sys, // Sampling clock
   input wire logic pin, // Pin level
   input wire logic oe, // Pin drive enable
   output int period // Rise-to-rise period in cycles
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Period measurement
   // ----------------------------------------
   logic prev = 1'b0;
   int n = 0;
   wire logic lvl = oe ? pin : !prev;
   initial period = 0;
   always @(posedge clk_sys)
   begin
      prev <= lvl;
      n <= (lvl && !prev) ? 1 : n + 1;
      if (lvl && !prev)
      begin
         period <= n;
      end
   end
endmodule

// ---- tb/scp_prescaler_test.sv ----
// Self-checking bench for the clock prescaler
// Assumes the checker is bound and the clock sink models the pin load
module scp_prescaler_test
   import scp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Harness, bus tasks and scenarios
   // ----------------------------------------
   logic clk_sys, rst, fuse, div8, rc, pout, poe, pin, pin_oe, tosc, ext, re;
   logic [7:0] ftrim, trim;
   logic [31:0] rq;
   scp_apb_req_t req;
   scp_apb_rsp_t rsp;
   scp_domain_en_t de;
   int period, n_fail = 0, tests_run = 0, cyc = 0;
   scp_prescaler scp_prescaler_inst (.clk_sys(clk_sys), .rst(rst), .apb_req(req), .apb_rsp(rsp),
      .clock_out_fuse(fuse), .start_div8_fuse(div8), .factory_trim(ftrim), .rc_source_selected(rc),
      .port_pin_out(pout), .port_pin_oe(poe), .domain_en(de), .clock_out_pin(pin), .clock_out_pin_oe(pin_oe),
      .oscillator_trim(trim), .timer_osc_enable(tosc), .ext_timer_clock_select(ext));
   scp_clock_sink scp_clock_sink_inst (.clk_sys(clk_sys), .pin(pin), .oe(pin_oe), .period(period));
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         n_fail++;
         results();
      end
   end
   task results();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Called just after an edge; a kept request lets the next setup follow at once
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic rel = 1'b1);
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= w;
      req.paddr <= a;
      req.pwdata <= d;
      @(posedge clk_sys);
      req.penable <= 1'b1;
      do @(posedge clk_sys); while (rsp.pready !== 1'b1);
      rq = rsp.prdata;
      re = rsp.pslverr;
      if (rel)
      begin
         req.psel <= 1'b0;
         req.penable <= 1'b0;
         @(posedge clk_sys);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe = 1'b0);
      xfer(1'b0, a, 32'h0);
      if (!xe)
         check("rdata", rq, x);
      check("pslverr", re, xe);
   endtask
   task automatic chg(input logic [3:0] c);
      xfer(1'b1, 8'h00, 32'h80, 1'b0);
      xfer(1'b1, 8'h00, {28'h0, c});
   endtask
   task automatic gap(output int g);
      g = 0;
      do @(posedge clk_sys); while (de.core_domain_clock !== 1'b1);
      do
      begin
         @(posedge clk_sys);
         g++;
      end
      while (de.core_domain_clock !== 1'b1);
   endtask
   task automatic t_reset();
      int g;
      rd(8'h00, 32'h03);
      rd(8'h04, 32'h5A);
      gap(g);
      gap(g);
      check("gap", g, 8);
      check("pin period", period, 8);
   endtask
   task automatic t_codes();
      int g;
      for (int c = 0; c <= 8; c++)
      begin
         chg(c[3:0]);
         rd(8'h00, c);
         gap(g);
         gap(g);
         gap(g);
         check("gap", g, 1 << c);
         if (c > 0)
            check("pin period", period, 1 << c);
      end
   endtask
   task automatic t_refuse();
      int g;
      xfer(1'b1, 8'h00, 32'h05);
      rd(8'h00, 32'h08);
      xfer(1'b1, 8'h00, 32'h81, 1'b0);
      xfer(1'b1, 8'h00, 32'h02);
      rd(8'h00, 32'h08);
      xfer(1'b1, 8'h00, 32'h80, 1'b0);
      rd(8'h00, 32'h88);
      rd(8'h00, 32'h08);
      xfer(1'b1, 8'h00, 32'h80, 1'b0);
      xfer(1'b1, 8'h00, 32'h80, 1'b0);
      xfer(1'b1, 8'h00, 32'h02);
      rd(8'h00, 32'h08);
      chg(4'h9);
      rd(8'h00, 32'h09);
      rd(8'h0C, 32'h81);
      gap(g);
      check("gap", g, 256);
      chg(4'h0);
   endtask
   task automatic t_regs();
      xfer(1'b1, 8'h04, 32'h7F); // no memory writes in this run
      check("trim", trim, 8'h7F);
      xfer(1'b1, 8'h04, 32'h80);
      rd(8'h04, 32'h80);
      xfer(1'b1, 8'h08, 32'h03);
      @(posedge clk_sys);
      check("timer osc", tosc, 0);
      check("ext clock", ext, 1);
      rc <= 1'b1; // undivided system clock, far above the timer oscillator
      repeat (2) @(posedge clk_sys);
      check("timer osc", tosc, 1);
      rd(8'h10, 32'h0, 1'b1);
   endtask
   task automatic t_pin();
      fuse <= 1'b0;
      pout <= 1'b1;
      poe <= 1'b1;
      repeat (3) @(posedge clk_sys);
      check("pin", {pin_oe, pin}, 2'b11);
      fuse <= 1'b1;
      chg(4'h4);
      rst <= 1'b1;
      repeat (60) @(posedge clk_sys);
      check("pin period", period, 8);
      div8 <= 1'b0;
      @(posedge clk_sys);
      rst <= 1'b0;
      rd(8'h00, 32'h00);
      rd(8'h04, 32'h5A);
      check("timer osc", tosc, 0);
      check("ext clock", ext, 0);
   endtask
   initial
   begin
      rst = 1'b1;
      fuse = 1'b1;
      div8 = 1'b1;
      rc = 1'b0;
      pout = 1'b0;
      poe = 1'b0;
      ftrim = 8'h5A;
      req = '0;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset();
      t_codes();
      t_refuse();
      t_regs();
      t_pin();
      results();
   end
endmodule
